// ===== bdm_defines.svh
// Address map, reset values and sizes of the banked data memory
`ifndef BDM_DEFINES_SVH
`define BDM_DEFINES_SVH
`define BDM_ADDR_WINDOW_A 8'h00
`define BDM_ADDR_POINTER_A 8'h01
`define BDM_ADDR_WINDOW_B 8'h02
`define BDM_ADDR_POINTER_B 8'h03
`define BDM_ADDR_BANK_SELECT 8'h04
`define BDM_ADDR_ACCUMULATOR 8'h05
`define BDM_ADDR_PC_LOW 8'h06
`define BDM_LAST_SFR 8'h23
`define BDM_GP_BASE 8'h40
`define BDM_GP_DEPTH 160
`define BDM_BANK1_DEPTH 11
`define BDM_BANK_ZERO 8'h00
`define BDM_BANK_ONE 8'h01
`define BDM_ZERO_BYTE 8'h00
`endif

// ===== bdm_pkg.sv
// Types shared by the banked data memory
package bdm_pkg;
	typedef enum logic [2:0] {
		BDM_OP_NONE,
		BDM_OP_READ,
		BDM_OP_WRITE,
		BDM_OP_BIT_SET,
		BDM_OP_BIT_CLR,
		BDM_OP_ALU
	} bdm_op_t;
	typedef struct packed {
		bdm_op_t op;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [2:0] bit_sel;
	} bdm_req_t;
	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
	} bdm_rsp_t;
	typedef enum logic {
		BDM_RUN,
		BDM_DUMMY
	} bdm_state_t;
endpackage

// ===== bdm_data_memory.sv
// Banked data memory with indirect windows, pointers, accumulator and program counter low byte
`timescale 1ns/1ps
`include "bdm_defines.svh"

module bdm_data_memory #(
	parameter int GP_DEPTH = `BDM_GP_DEPTH,
	parameter int BANK1_DEPTH = `BDM_BANK1_DEPTH,
	parameter logic [7:0] READ_ONLY_ADDR = 8'h08
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_enable,
	input bdm_pkg::bdm_req_t i_req,
	input wire logic [7:0] i_alu_result,
	input wire logic [7:0] i_ext_rdata,
	output bdm_pkg::bdm_rsp_t o_rsp,
	output logic [7:0] o_accumulator,
	output logic [7:0] o_pc_low,
	output logic o_pc_load,
	output logic o_dummy_cycle,
	output logic o_ext_we,
	output logic [7:0] o_ext_addr,
	output logic [7:0] o_ext_wdata,
	output logic o_ext_bank1
);
	import bdm_pkg::*;

	// ==========================================================
	// Storage
	logic [7:0] pointer_a;
	logic [7:0] pointer_b;
	logic [7:0] bank_select;
	logic [7:0] accumulator;
	logic [7:0] program_counter_low;
	logic [7:0] gp_ram [0:GP_DEPTH-1];
	logic [7:0] bank1_ram [0:BANK1_DEPTH-1];
	bdm_state_t state;

	function automatic logic [7:0] bit_update(input logic [7:0] v, input logic [2:0] b, input logic s);
		logic [7:0] r;
		r = v;
		r[b] = s;
		return r;
	endfunction

	function automatic logic in_gp(input logic [7:0] a);
		return (a >= `BDM_GP_BASE) && ({24'h0, a} < (32'(`BDM_GP_BASE) + GP_DEPTH));
	endfunction

	// ==========================================================
	// Address resolution
	wire logic is_window_a = (i_req.addr == `BDM_ADDR_WINDOW_A);
	wire logic is_window_b = (i_req.addr == `BDM_ADDR_WINDOW_B);
	// Window A never leaves bank zero; direct access neither
	wire logic [7:0] eff_addr = is_window_a ? pointer_a : (is_window_b ? pointer_b : i_req.addr);
	wire logic eff_bank1 = is_window_b && (bank_select == `BDM_BANK_ONE);
	wire logic indirect = is_window_a || is_window_b;
	wire logic eff_is_window = (eff_addr == `BDM_ADDR_WINDOW_A) || (eff_addr == `BDM_ADDR_WINDOW_B);
	wire logic null_target = indirect && eff_is_window && !eff_bank1;
	wire logic eff_gp = !eff_bank1 && in_gp(eff_addr);
	wire logic [7:0] gp_index = 8'(eff_addr - `BDM_GP_BASE);
	wire logic eff_b1_ok = eff_bank1 && ({24'h0, eff_addr} < BANK1_DEPTH);
	wire logic eff_ext = !eff_bank1 && !null_target && (eff_addr > `BDM_ADDR_PC_LOW) && (eff_addr <= `BDM_LAST_SFR);
	wire logic eff_read_only = !eff_bank1 && (eff_addr == READ_ONLY_ADDR);

	// ==========================================================
	// Read path
	logic [7:0] cur_value;
	always_comb begin
		cur_value = `BDM_ZERO_BYTE;
		if (null_target) begin
			cur_value = `BDM_ZERO_BYTE;
		end else if (eff_b1_ok) begin
			cur_value = bank1_ram[eff_addr[3:0]];
		end else if (eff_gp) begin
			cur_value = gp_ram[gp_index];
		end else if (eff_ext) begin
			cur_value = i_ext_rdata;
		end else if (!eff_bank1) begin
			case (eff_addr)
				`BDM_ADDR_POINTER_A: cur_value = pointer_a;
				`BDM_ADDR_POINTER_B: cur_value = pointer_b;
				`BDM_ADDR_BANK_SELECT: cur_value = bank_select;
				`BDM_ADDR_ACCUMULATOR: cur_value = accumulator;
				`BDM_ADDR_PC_LOW: cur_value = program_counter_low;
				default: cur_value = `BDM_ZERO_BYTE;
			endcase
		end
	end

	// ==========================================================
	// Write path
	wire logic op_write = (i_req.op == BDM_OP_WRITE);
	wire logic op_bit = (i_req.op == BDM_OP_BIT_SET) || (i_req.op == BDM_OP_BIT_CLR);
	wire logic active = i_enable && (state == BDM_RUN);
	wire logic do_store = active && (op_write || op_bit) && !null_target && !eff_read_only;
	wire logic [7:0] store_value = op_bit ? bit_update(cur_value, i_req.bit_sel, i_req.op == BDM_OP_BIT_SET)
		: i_req.wdata;
	wire logic sfr_store = do_store && !eff_bank1;
	wire logic pc_store = sfr_store && (eff_addr == `BDM_ADDR_PC_LOW);
	wire logic alu_store = active && (i_req.op == BDM_OP_ALU);

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			pointer_a <= `BDM_ZERO_BYTE;
			pointer_b <= `BDM_ZERO_BYTE;
			bank_select <= `BDM_BANK_ZERO;
			accumulator <= `BDM_ZERO_BYTE;
			program_counter_low <= `BDM_ZERO_BYTE;
		end else if (i_enable) begin
			if (sfr_store && eff_addr == `BDM_ADDR_POINTER_A) pointer_a <= store_value;
			if (sfr_store && eff_addr == `BDM_ADDR_POINTER_B) pointer_b <= store_value;
			if (sfr_store && eff_addr == `BDM_ADDR_BANK_SELECT) bank_select <= store_value;
			if (alu_store) begin
				accumulator <= i_alu_result;
			end else if (sfr_store && eff_addr == `BDM_ADDR_ACCUMULATOR) begin
				accumulator <= store_value;
			end
			if (pc_store) program_counter_low <= store_value;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_enable && do_store && eff_gp) gp_ram[gp_index] <= store_value;
		if (i_enable && do_store && eff_b1_ok) bank1_ram[eff_addr[3:0]] <= store_value;
	end

	// ==========================================================
	// Dummy cycle after a jump
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= BDM_RUN;
		end else if (i_enable) begin
			case (state)
				BDM_RUN: if (pc_store) state <= BDM_DUMMY;
				BDM_DUMMY: state <= BDM_RUN;
				default: state <= BDM_RUN;
			endcase
		end
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rsp <= '0;
			o_pc_load <= 1'b0;
			o_dummy_cycle <= 1'b0;
			o_ext_we <= 1'b0;
			o_ext_addr <= `BDM_ZERO_BYTE;
			o_ext_wdata <= `BDM_ZERO_BYTE;
			o_ext_bank1 <= 1'b0;
		end else if (i_enable) begin
			o_rsp.valid <= active && (i_req.op == BDM_OP_READ);
			o_rsp.rdata <= cur_value;
			o_pc_load <= pc_store;
			o_dummy_cycle <= pc_store;
			o_ext_we <= do_store && eff_ext;
			o_ext_addr <= eff_addr;
			o_ext_wdata <= store_value;
			o_ext_bank1 <= eff_bank1;
		end
	end

	assign o_accumulator = accumulator;
	assign o_pc_low = program_counter_low;

	// ==========================================================
	// Checks
	property p_pc_jump;
		@(posedge i_clock) disable iff (!i_resetn)
		(pc_store) |=> (o_pc_load && o_dummy_cycle && o_pc_low == $past(store_value));
	endproperty
	a_pc_jump: assert property (p_pc_jump) else $error("pc low write did not jump");

	sequence s_jump;
		i_enable && pc_store;
	endsequence
	property p_dummy;
		@(posedge i_clock) disable iff (!i_resetn)
		s_jump |=> (state == BDM_DUMMY) ##1 (!i_enable || state == BDM_RUN);
	endproperty
	a_dummy: assert property (p_dummy) else $error("dummy cycle missing");

	property p_null_read;
		@(posedge i_clock) disable iff (!i_resetn)
		(i_enable && active && i_req.op == BDM_OP_READ && null_target) |=> (o_rsp.valid && o_rsp.rdata == 8'h00);
	endproperty
	a_null_read: assert property (p_null_read) else $error("window through pointer not zero");

	property p_unused_zero;
		@(posedge i_clock) disable iff (!i_resetn)
		(i_enable && active && i_req.op == BDM_OP_READ && !indirect && i_req.addr > `BDM_LAST_SFR
			&& i_req.addr < `BDM_GP_BASE) |=> (o_rsp.rdata == 8'h00);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused location not zero");

	property p_direct_bank0;
		@(posedge i_clock) disable iff (!i_resetn)
		(i_enable && !is_window_b) |-> !eff_bank1;
	endproperty
	a_direct_bank0: assert property (p_direct_bank0) else $error("bank one reached without window b");

	property p_bank_sel;
		@(posedge i_clock) disable iff (!i_resetn)
		(is_window_b && bank_select == 8'h00) |-> !eff_bank1;
	endproperty
	a_bank_sel: assert property (p_bank_sel) else $error("bank zero not selected");

	property p_ptr_write;
		@(posedge i_clock) disable iff (!i_resetn)
		(sfr_store && eff_addr == 8'h01 && !alu_store) |=> (pointer_a == $past(store_value));
	endproperty
	a_ptr_write: assert property (p_ptr_write) else $error("pointer a not written");

	property p_alu;
		@(posedge i_clock) disable iff (!i_resetn)
		alu_store |=> (o_accumulator == $past(i_alu_result));
	endproperty
	a_alu: assert property (p_alu) else $error("alu result not in accumulator");

	property p_read_only;
		@(posedge i_clock) disable iff (!i_resetn)
		(i_enable && eff_read_only) |-> !do_store;
	endproperty
	a_read_only: assert property (p_read_only) else $error("read-only location written");

	sequence s_read_taken;
		active && (i_req.op == BDM_OP_READ);
	endsequence
	property p_read_valid;
		@(posedge i_clock) disable iff (!i_resetn)
		s_read_taken |=> o_rsp.valid;
	endproperty
	a_read_valid: assert property (p_read_valid) else $error("read not answered");

	property p_dummy_refuse;
		@(posedge i_clock) disable iff (!i_resetn)
		(state == BDM_DUMMY) |-> !active;
	endproperty
	a_dummy_refuse: assert property (p_dummy_refuse) else $error("request taken in dummy cycle");

	property p_window_a_bank0;
		@(posedge i_clock) disable iff (!i_resetn)
		is_window_a |-> !eff_bank1;
	endproperty
	a_window_a_bank0: assert property (p_window_a_bank0) else $error("window a left bank zero");

	property p_b1_unimpl;
		@(posedge i_clock) disable iff (!i_resetn)
		(i_enable && eff_bank1 && !eff_b1_ok) |-> (cur_value == 8'h00);
	endproperty
	a_b1_unimpl: assert property (p_b1_unimpl) else $error("unused bank one location not zero");

	// Peripheral write forwarded one cycle later
	sequence s_ext_store;
		do_store && eff_ext;
	endsequence
	property p_ext_write;
		@(posedge i_clock) disable iff (!i_resetn)
		s_ext_store |=> (o_ext_we && o_ext_addr == $past(eff_addr) && o_ext_wdata == $past(store_value));
	endproperty
	a_ext_write: assert property (p_ext_write) else $error("peripheral write not forwarded");

	property p_freeze;
		@(posedge i_clock) disable iff (!i_resetn)
		!i_enable |=> ($stable(accumulator) && $stable(pointer_a) && $stable(pointer_b) && $stable(bank_select));
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

	sequence s_b1_store;
		do_store && eff_b1_ok;
	endsequence
	property p_b1_write;
		@(posedge i_clock) disable iff (!i_resetn)
		s_b1_store |=> (bank1_ram[$past(eff_addr[3:0])] == $past(store_value));
	endproperty
	a_b1_write: assert property (p_b1_write) else $error("bank one location not written");
endmodule

// ===== bdm_data_memory_tb.sv
// Self-checking testbench of the banked data memory
`timescale 1ns/1ps
`include "bdm_defines.svh"
module bdm_data_memory_tb;
	import bdm_pkg::*;
	// ====================
	// Signals and instance
	logic i_clock = 1'b0;
	logic i_resetn = 1'b0;
	logic i_enable = 1'b1;
	bdm_req_t i_req = '0;
	logic [7:0] i_alu_result = 8'h00;
	logic [7:0] i_ext_rdata = 8'h00;
	bdm_rsp_t o_rsp;
	logic [7:0] o_accumulator;
	logic [7:0] o_pc_low;
	logic o_pc_load;
	logic o_dummy_cycle;
	logic o_ext_we;
	logic [7:0] o_ext_addr;
	logic [7:0] o_ext_wdata;
	logic o_ext_bank1;
	int fail_count = 0;
	int samples_checked = 0;
	int cycle_count = 0;

	bdm_data_memory uut (.i_clock(i_clock), .i_resetn(i_resetn), .i_enable(i_enable), .i_req(i_req),
		.i_alu_result(i_alu_result), .i_ext_rdata(i_ext_rdata), .o_rsp(o_rsp), .o_accumulator(o_accumulator),
		.o_pc_low(o_pc_low), .o_pc_load(o_pc_load), .o_dummy_cycle(o_dummy_cycle), .o_ext_we(o_ext_we),
		.o_ext_addr(o_ext_addr), .o_ext_wdata(o_ext_wdata), .o_ext_bank1(o_ext_bank1));

	always #10 i_clock = ~i_clock;

	// ====================
	// Access tasks
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Request held from just after one edge until just after the taking edge
	task automatic drive(input bdm_op_t op, input logic [7:0] addr, input logic [7:0] wdata, input logic [2:0] bsel);
		i_req = '{op, addr, wdata, bsel};
		@(posedge i_clock);
		#1;
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		drive(BDM_OP_WRITE, addr, data, 3'd0);
	endtask

	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		drive(BDM_OP_READ, addr, 8'h00, 3'd0);
		check({7'h00, o_rsp.valid}, 8'h01, "read valid");
		check(o_rsp.rdata, exp, "read data");
	endtask

	// Hang guard, tests need about 54 cycles
	always @(posedge i_clock) begin
		cycle_count++;
		if (cycle_count == 2000) begin
			fail_count++;
			$display("wrong value at %0t: run timed out", $time);
			report_and_stop();
		end
	end

	// ====================
	// Tests
	initial begin
		repeat (3) @(posedge i_clock);
		#1;
		i_resetn = 1'b1;
		check(o_accumulator, 8'h00, "acc after reset");
		check(o_pc_low, 8'h00, "pc low after reset");
		wr(8'h40, 8'h5A);
		wr(8'hDF, 8'hC3);
		rd(8'h40, 8'h5A);
		rd(8'hDF, 8'hC3);
		drive(BDM_OP_BIT_SET, 8'h40, 8'h00, 3'd7);
		drive(BDM_OP_BIT_CLR, 8'h40, 8'h00, 3'd1);
		rd(8'h40, 8'hD8);
		wr(8'h3F, 8'h66);
		rd(8'h3F, 8'h00);
		rd(8'h24, 8'h00);
		$display("general area test done");
		wr(`BDM_ADDR_POINTER_A, 8'h41);
		rd(`BDM_ADDR_POINTER_A, 8'h41);
		wr(`BDM_ADDR_WINDOW_A, 8'h77);
		rd(8'h41, 8'h77);
		rd(`BDM_ADDR_WINDOW_A, 8'h77);
		wr(`BDM_ADDR_POINTER_A, `BDM_ADDR_WINDOW_A);
		rd(`BDM_ADDR_WINDOW_A, 8'h00);
		wr(`BDM_ADDR_WINDOW_A, 8'h11);
		wr(`BDM_ADDR_POINTER_A, `BDM_ADDR_WINDOW_B);
		rd(`BDM_ADDR_WINDOW_A, 8'h00);
		$display("window a test done");
		wr(`BDM_ADDR_BANK_SELECT, `BDM_BANK_ONE);
		rd(`BDM_ADDR_BANK_SELECT, `BDM_BANK_ONE);
		wr(`BDM_ADDR_POINTER_B, 8'h03);
		wr(`BDM_ADDR_WINDOW_B, 8'hA5);
		check({7'h00, o_ext_bank1}, 8'h01, "bank one flag");
		rd(`BDM_ADDR_WINDOW_B, 8'hA5);
		rd(`BDM_ADDR_POINTER_B, 8'h03);
		check({7'h00, o_ext_bank1}, 8'h00, "direct stays bank zero");
		wr(`BDM_ADDR_POINTER_A, 8'h41);
		rd(`BDM_ADDR_WINDOW_A, 8'h77);
		wr(`BDM_ADDR_POINTER_B, 8'h0B);
		wr(`BDM_ADDR_WINDOW_B, 8'h33);
		rd(`BDM_ADDR_WINDOW_B, 8'h00);
		wr(`BDM_ADDR_BANK_SELECT, `BDM_BANK_ZERO);
		wr(`BDM_ADDR_POINTER_B, 8'h03);
		rd(`BDM_ADDR_WINDOW_B, 8'h03);
		$display("bank test done");
		i_alu_result = 8'h3C;
		drive(BDM_OP_ALU, 8'h40, 8'h00, 3'd0);
		check(o_accumulator, 8'h3C, "alu into acc");
		rd(8'h40, 8'hD8);
		rd(`BDM_ADDR_ACCUMULATOR, 8'h3C);
		wr(`BDM_ADDR_ACCUMULATOR, 8'h99);
		check(o_accumulator, 8'h99, "acc write");
		i_enable = 1'b0;
		wr(`BDM_ADDR_ACCUMULATOR, 8'h55);
		check(o_accumulator, 8'h99, "acc frozen while disabled");
		i_enable = 1'b1;
		$display("accumulator test done");
		wr(`BDM_ADDR_PC_LOW, 8'hF0);
		check({6'h00, o_pc_load, o_dummy_cycle}, 8'h03, "jump pulses");
		check(o_pc_low, 8'hF0, "pc low");
		drive(BDM_OP_READ, 8'h40, 8'h00, 3'd0);
		check({6'h00, o_rsp.valid, o_pc_load}, 8'h00, "dummy cycle");
		rd(8'h40, 8'hD8);
		$display("pc low test done");
		i_ext_rdata = 8'h6E;
		rd(8'h09, 8'h6E);
		wr(8'h09, 8'h12);
		check({7'h00, o_ext_we}, 8'h01, "ext write");
		check(o_ext_addr, 8'h09, "ext addr");
		check(o_ext_wdata, 8'h12, "ext data");
		drive(BDM_OP_BIT_SET, 8'h09, 8'h00, 3'd0);
		check(o_ext_wdata, 8'h6F, "ext bit set data");
		wr(8'h08, 8'h34);
		check({7'h00, o_ext_we}, 8'h00, "read only write");
		drive(BDM_OP_BIT_SET, 8'h08, 8'h00, 3'd2);
		check({7'h00, o_ext_we}, 8'h00, "read only bit set");
		drive(BDM_OP_NONE, 8'h00, 8'h00, 3'd0);
		i_resetn = 1'b0;
		@(posedge i_clock);
		#1;
		check(o_accumulator, 8'h00, "acc after second reset");
		i_resetn = 1'b1;
		rd(`BDM_ADDR_POINTER_A, 8'h00);
		rd(`BDM_ADDR_BANK_SELECT, `BDM_BANK_ZERO);
		$display("peripheral and reset test done");
		report_and_stop();
	end
endmodule
